// ---- hdl/lbc_pkg.sv ----
package lbc_pkg;

  // cycle status codes, most significant bit first
  localparam logic [2:0] CSC_INTERRUPT_ACKNOWLEDGE_STROBE    = 3'h0;
  localparam logic [2:0] CSC_IO_RD   = 3'h1;
  localparam logic [2:0] CSC_IO_WR   = 3'h2;
  localparam logic [2:0] CSC_HALT    = 3'h3;
  localparam logic [2:0] CSC_FETCH   = 3'h4;
  localparam logic [2:0] CSC_MEM_RD  = 3'h5;
  localparam logic [2:0] CSC_MEM_WR  = 3'h6;
  localparam logic [2:0] CSC_PASSIVE = 3'h7;

  // user command kinds
  typedef enum logic [2:0] {
    LBC_CMD_READ,
    LBC_CMD_FETCH,
    LBC_CMD_WRITE,
    LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE,
    LBC_CMD_HALT,
    LBC_CMD_LOCK,
    LBC_CMD_WAIT,
    LBC_CMD_UNLOCK
  } lbc_cmd_t;

  localparam int DATA_W        = 16;
  localparam int ADDR_W        = 20;
  localparam int CMD_W         = 3 + 1 + 1 + ADDR_W + DATA_W;
  localparam int FIFO_DEPTH    = 32;
  localparam int TEST_LOW_NS   = 5 * 4;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TEST_LOW_CYC  = (TEST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VEC_SHIFT     = 2;

  // byte-lane select: hbe_n / a0
  function automatic logic [1:0] lbc_lanes(input logic hbe_n, input logic a0);
    lbc_lanes = {~hbe_n, ~a0};
  endfunction

endpackage

// ---- hdl/lbc_if.sv ----
`timescale 1ns/1ps
interface lbc_if;
  logic [15:0] ad_o;
  logic [15:0] ad_oe;
  logic [15:0] ad_i;
  logic [15:0] per_ad_o;
  logic        per_ad_oe;
  logic [3:0]  a_hi;
  logic        ale;
  logic        rd_n;
  logic        wr_n;
  logic        mio;
  logic        high_byte_enable_n;
  logic        interrupt_acknowledge_strobe_n;
  logic        transceiver_direction;
  logic        transceiver_output_enable_n;
  logic [2:0]  cycle_status_code;
  logic        lock_n;
  logic        ctrl_oe;
  logic        ready;
  logic        test_n;
  logic        hold_req;
  logic        hold_ack;
  logic        bus_mode_strap;

  assign ad_i = per_ad_oe ? per_ad_o : ad_o;

  modport cpu (
    output ad_o, ad_oe, a_hi, ale, rd_n, wr_n, mio, high_byte_enable_n,
           interrupt_acknowledge_strobe_n, transceiver_direction, transceiver_output_enable_n,
           cycle_status_code, lock_n, ctrl_oe, hold_ack,
    input  ad_i, ready, test_n, hold_req, bus_mode_strap
  );
  modport bus (
    output per_ad_o, per_ad_oe, ready, test_n, hold_req, bus_mode_strap,
    input  ad_o, ad_oe, a_hi, ale, rd_n, wr_n, mio, high_byte_enable_n,
           interrupt_acknowledge_strobe_n, transceiver_direction, transceiver_output_enable_n,
           cycle_status_code, lock_n, ctrl_oe, hold_ack
  );
endinterface

// ---- hdl/lbc_fifo.sv ----
`timescale 1ns/1ps
module lbc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_param_chk
    $error("lbc_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      wp_d;
  logic [AW:0]      rp_q;
  logic [AW:0]      rp_d;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    out_valid = wp_q != rp_q;
    out_data  = mem[rp_q[AW-1:0]];
    push      = clk_en & in_valid & in_ready;
    pop       = clk_en & out_valid & out_ready;
    wp_d      = push ? wp_q + 1'b1 : wp_q;
    rp_d      = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage without reset: contents are qualified by the pointers
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ---- hdl/lbc_cpu_end.sv ----
// Operation
// R1 - minimum-mode halt: one strobe, no qualifiers
// R2 - maximum-mode halt drives halt status code
// R3 - bus grant never ends the halt
// R4 - lock asserts cycle after prefix decode
// R5 - lock released after next instruction's cycles
// R6 - requests during lock granted after release; in halt and wait the code grants them even while lock is set
// R7 - wait suspends idle while test high
// R8 - external logic holds test low five cycles; the bus end holds it low six
// R9 - interrupt in wait: refetch, service, rewait
// R10 - hold granted floats all bus drivers
// R11 - strap high strobes, low coded status
// R12 - cycle starts T1 with address strobe
// R13 - memory/IO select held T1 to T4
// R14 - read floats bus, strobe in T2
// R15 - responder drives data while read low
// R16 - write data from T2 to T4
// R17 - write strobe T2 through wait states
// R18 - lanes from high-byte enable and A0
// R19 - even bytes low lines, odd high
// R20 - acknowledge like read, address floated
// R21 - second acknowledge type byte times four
// R22 - max mode signals cycle type
// R23 - status code table encodings
// R24 - wait states while ready low
`timescale 1ns/1ps
module lbc_cpu_end
  import lbc_pkg::*;
#(
  parameter int DEPTH = lbc_pkg::FIFO_DEPTH
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  lbc_if.cpu                              bus,
  input  wire logic [lbc_pkg::CMD_W-1:0]  cmd_data,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic                       intr_req,
  output logic [lbc_pkg::DATA_W-1:0]      rsp_data,
  output logic                            rsp_valid,
  output logic [9:0]                      vec_ptr,
  output logic                            vec_valid,
  output logic                            halted,
  output logic                            waiting
);
  import lbc_pkg::*;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("lbc_cpu_end: depth must be a power of two >= 2");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_HALT, ST_WAIT, ST_HOLD
  } lbc_state_t;

  logic [CMD_W-1:0] f_data;
  logic             f_valid;
  logic             f_ready;

  lbc_fifo #(.WIDTH(CMD_W), .DEPTH(DEPTH)) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .in_data  (cmd_data),
    .in_valid (cmd_valid),
    .in_ready (cmd_ready),
    .out_data (f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  lbc_cmd_t    f_cmd;
  logic        f_io;
  logic        f_hbe_n;
  logic [19:0] f_addr;
  logic [15:0] f_wdat;
  assign f_cmd = lbc_cmd_t'(f_data[CMD_W-1 -: 3]);
  assign {f_io, f_hbe_n, f_addr, f_wdat} = f_data[CMD_W-4:0];

  lbc_state_t  st_q, st_d;
  lbc_cmd_t    cmd_q, cmd_d;
  logic        io_q, io_d;
  logic        hbe_q, hbe_d;
  logic [19:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d;
  logic        lock_q, lock_d;
  logic        inta2_q, inta2_d;
  logic        ret_wait_q, ret_wait_d;
  lbc_state_t  hold_ret_q, hold_ret_d;
  logic        hold_pend_q, hold_pend_d;
  logic [15:0] ad_o_q, ad_o_d;
  logic [15:0] ad_oe_q, ad_oe_d;
  logic        ale_q, ale_d, rd_q, rd_d, wr_q, wr_d, interrupt_acknowledge_strobe_q, interrupt_acknowledge_strobe_d, mio_q, mio_d;
  logic        dtr_q, dtr_d, den_q, den_d, hack_q, hack_d;
  logic [2:0]  csc_q, csc_d;
  logic [15:0] rsp_q, rsp_d;
  logic        rv_q, rv_d, vv_q, vv_d;
  logic [9:0]  vec_q, vec_d;
  logic        minm;
  logic        is_rd;
  logic        is_wr;

  assign minm  = bus.bus_mode_strap; // R11
  assign is_rd = (cmd_q == LBC_CMD_READ) || (cmd_q == LBC_CMD_FETCH);
  assign is_wr = cmd_q == LBC_CMD_WRITE;

  function automatic logic [2:0] code_of(input lbc_cmd_t c, input logic io);
    case (c)
      LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE:  code_of = CSC_INTERRUPT_ACKNOWLEDGE_STROBE;
      LBC_CMD_HALT:  code_of = CSC_HALT;
      LBC_CMD_FETCH: code_of = CSC_FETCH;
      LBC_CMD_READ:  code_of = io ? CSC_IO_RD : CSC_MEM_RD;
      LBC_CMD_WRITE: code_of = io ? CSC_IO_WR : CSC_MEM_WR;
      default:       code_of = CSC_PASSIVE;
    endcase
  endfunction

  always_comb begin
    st_d = st_q; cmd_d = cmd_q; io_d = io_q; hbe_d = hbe_q; addr_d = addr_q; wdat_d = wdat_q;
    lock_d = lock_q; inta2_d = inta2_q; ret_wait_d = ret_wait_q;
    hold_ret_d = hold_ret_q; hold_pend_d = hold_pend_q | bus.hold_req; // R6
    ad_o_d = ad_o_q; ad_oe_d = ad_oe_q; ale_d = 1'b0; rd_d = 1'b0; wr_d = 1'b0; interrupt_acknowledge_strobe_d = 1'b0;
    mio_d = mio_q; dtr_d = dtr_q; den_d = 1'b0; hack_d = hack_q; csc_d = CSC_PASSIVE;
    rsp_d = rsp_q; rv_d = 1'b0; vv_d = 1'b0; vec_d = vec_q; f_ready = 1'b0;
    case (st_q)
      ST_IDLE: begin
        ad_oe_d = '0;
        if (hold_pend_q && !lock_q) begin // R6
          st_d = ST_HOLD; hold_ret_d = ST_IDLE; hack_d = 1'b1; hold_pend_d = 1'b0;
        end else if (f_valid) begin
          f_ready = 1'b1;
          cmd_d = f_cmd; io_d = f_io; hbe_d = f_hbe_n; addr_d = f_addr; wdat_d = f_wdat;
          case (f_cmd)
            LBC_CMD_LOCK: lock_d = 1'b1; // R4
            LBC_CMD_UNLOCK: lock_d = 1'b0; // R5
            LBC_CMD_WAIT: if (bus.test_n) st_d = ST_WAIT; // R7
            default: begin
              st_d = ST_T1;
              ale_d = 1'b1; // R12 R1
              mio_d = ~f_io;  // R13
              dtr_d = (f_cmd == LBC_CMD_WRITE);
              ad_o_d = f_addr[15:0];
              ad_oe_d = (f_cmd == LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE) ? 16'h0000 : 16'hffff; // R20
              csc_d = minm ? CSC_PASSIVE : code_of(f_cmd, f_io); // R2 R22 R23
            end
          endcase
        end
      end
      ST_T1: begin
        st_d = (cmd_q == LBC_CMD_HALT) ? ST_HALT : ST_T2; // R1
        csc_d = minm ? CSC_PASSIVE : code_of(cmd_q, io_q); // R22
        ad_oe_d = is_wr ? 16'hffff : 16'h0000; // R14 R16
        ad_o_d = wdat_q;
        wr_d = is_wr & minm; // R17
        // the bus floats from the next cycle on, so the read strobe can open T2 with it
        rd_d = is_rd & minm; // R14
        interrupt_acknowledge_strobe_d = (cmd_q == LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE) & minm; // R20
        den_d = cmd_q != LBC_CMD_HALT;
      end
      ST_T2: begin
        st_d = ST_T3;
        rd_d = is_rd & minm; // R14
        interrupt_acknowledge_strobe_d = (cmd_q == LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE) & minm; // R20
        wr_d = is_wr & minm; // R17
        den_d = 1'b1;
      end
      ST_T3, ST_TW: begin
        rd_d = is_rd & minm; interrupt_acknowledge_strobe_d = (cmd_q == LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE) & minm; wr_d = is_wr & minm; den_d = 1'b1;
        if (bus.ready) begin // R24
          st_d = ST_T4;
          rd_d = 1'b0; interrupt_acknowledge_strobe_d = 1'b0; wr_d = 1'b0; // R16
          if (!is_wr) rsp_d = bus.ad_i;
          rv_d = is_rd;
          if (cmd_q == LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE) begin
            inta2_d = ~inta2_q;
            if (inta2_q) begin
              vec_d = {bus.ad_i[7:0], 2'h0}; vv_d = 1'b1; // R21 R19
            end
          end
        end else begin
          st_d = ST_TW;
        end
      end
      ST_T4: begin
        st_d = ret_wait_q ? ST_WAIT : ST_IDLE;
        ret_wait_d = 1'b0;
        ad_oe_d = '0;
      end
      ST_HALT: begin
        if (hold_pend_q) begin // R3
          st_d = ST_HOLD; hold_ret_d = ST_HALT; hack_d = 1'b1; hold_pend_d = 1'b0;
        end else if (intr_req) begin
          st_d = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (hold_pend_q) begin // R10
          st_d = ST_HOLD; hold_ret_d = ST_WAIT; hack_d = 1'b1; hold_pend_d = 1'b0;
        end else if (!bus.test_n) begin
          st_d = ST_IDLE; // R7
        end else if (intr_req) begin
          // one extra fetch of the wait opcode, then resume waiting
          st_d = ST_T1; cmd_d = LBC_CMD_FETCH; ale_d = 1'b1; mio_d = 1'b1; dtr_d = 1'b0; // R9
          ad_o_d = addr_q[15:0]; ad_oe_d = 16'hffff; ret_wait_d = 1'b1;
          csc_d = minm ? CSC_PASSIVE : CSC_FETCH;
        end
      end
      ST_HOLD: begin
        ad_oe_d = '0; // R10
        // the standing request is the one being served; recording it again would grant twice
        hold_pend_d = 1'b0;
        if (!bus.hold_req) begin
          st_d = hold_ret_q; hack_d = 1'b0;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE; cmd_q <= LBC_CMD_READ; io_q <= 1'b0; hbe_q <= 1'b1; addr_q <= '0; wdat_q <= '0;
      lock_q <= 1'b0; inta2_q <= 1'b0; ret_wait_q <= 1'b0;
      hold_ret_q <= ST_IDLE; hold_pend_q <= 1'b0; ad_o_q <= '0; ad_oe_q <= '0;
      ale_q <= 1'b0; rd_q <= 1'b0; wr_q <= 1'b0; interrupt_acknowledge_strobe_q <= 1'b0; mio_q <= 1'b0;
      dtr_q <= 1'b0; den_q <= 1'b0; hack_q <= 1'b0; csc_q <= CSC_PASSIVE;
      rsp_q <= '0; rv_q <= 1'b0; vv_q <= 1'b0; vec_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d; cmd_q <= cmd_d; io_q <= io_d; hbe_q <= hbe_d; addr_q <= addr_d; wdat_q <= wdat_d;
      lock_q <= lock_d; inta2_q <= inta2_d; ret_wait_q <= ret_wait_d;
      hold_ret_q <= hold_ret_d; hold_pend_q <= hold_pend_d; ad_o_q <= ad_o_d; ad_oe_q <= ad_oe_d;
      ale_q <= ale_d; rd_q <= rd_d; wr_q <= wr_d; interrupt_acknowledge_strobe_q <= interrupt_acknowledge_strobe_d; mio_q <= mio_d;
      dtr_q <= dtr_d; den_q <= den_d; hack_q <= hack_d; csc_q <= csc_d;
      rsp_q <= rsp_d; rv_q <= rv_d; vv_q <= vv_d; vec_q <= vec_d;
    end
  end

  assign bus.ad_o                           = ad_o_q;
  assign bus.ad_oe                          = ad_oe_q;
  assign bus.a_hi                           = addr_q[19:16];
  assign bus.ale                            = ale_q & minm; // R11
  assign bus.rd_n                           = ~rd_q;
  assign bus.wr_n                           = ~wr_q;
  assign bus.interrupt_acknowledge_strobe_n = ~interrupt_acknowledge_strobe_q;
  assign bus.mio                            = mio_q;
  assign bus.high_byte_enable_n             = hbe_q; // R18
  assign bus.transceiver_direction          = dtr_q;
  assign bus.transceiver_output_enable_n    = ~den_q;
  assign bus.cycle_status_code              = csc_q;
  assign bus.lock_n                         = ~lock_q;
  assign bus.ctrl_oe                        = ~hack_q; // R10
  assign bus.hold_ack                       = hack_q;
  assign rsp_data                           = rsp_q;
  assign rsp_valid                          = rv_q;
  assign vec_ptr                            = vec_q;
  assign vec_valid                          = vv_q;
  assign halted                             = st_q == ST_HALT;
  assign waiting                            = st_q == ST_WAIT;
endmodule

// ---- hdl/lbc_bus_end.sv ----
`timescale 1ns/1ps
module lbc_bus_end
  import lbc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  lbc_if.bus               bus,
  input  wire logic        mode_max_n,
  input  wire logic        test_release,
  input  wire logic        hold_want,
  input  wire logic [7:0]  int_type,
  input  wire logic        slow,
  output logic [19:0]      last_addr,
  output logic [15:0]      last_wdata,
  output logic             wdata_valid
);
  import lbc_pkg::*;

  logic [15:0] mem_q, mem_d;
  logic [19:0] lat_q, lat_d;
  logic [15:0] wd_q, wd_d;
  logic        wv_q, wv_d, rdy_q, rdy_d, oe_q, oe_d, tn_q, tn_d;
  logic [2:0]  tcnt_q, tcnt_d;
  logic [2:0]  ps_q, ps_d, code_q, code_d;
  logic        start, rd_act, ack_act, wr_act;

  // with the strap low this end stands in for the bus controller: status leaving passive
  // marks T1, and the transceiver enable frames the data phase
  assign start   = bus.bus_mode_strap ? bus.ale
                                      : (bus.cycle_status_code != CSC_PASSIVE) && (ps_q == CSC_PASSIVE); // R2
  assign rd_act  = bus.bus_mode_strap ? !bus.rd_n
                                      : (code_q inside {CSC_IO_RD, CSC_MEM_RD, CSC_FETCH})
                                        && !bus.transceiver_output_enable_n;
  assign ack_act = bus.bus_mode_strap ? !bus.interrupt_acknowledge_strobe_n
                                      : (code_q == CSC_INTERRUPT_ACKNOWLEDGE_STROBE) && !bus.transceiver_output_enable_n;
  assign wr_act  = bus.bus_mode_strap ? !bus.wr_n
                                      : (code_q inside {CSC_IO_WR, CSC_MEM_WR}) && !bus.transceiver_output_enable_n;

  always_comb begin
    mem_d = mem_q; lat_d = lat_q; wd_d = wd_q; wv_d = 1'b0; oe_d = 1'b0;
    rdy_d = ~slow; tn_d = tn_q; tcnt_d = tcnt_q;
    ps_d = bus.cycle_status_code;
    code_d = start ? bus.cycle_status_code : code_q;
    if (start) lat_d = {bus.a_hi, bus.ad_o}; // R12
    if (rd_act || ack_act) oe_d = 1'b1; // R15
    if (wr_act) begin
      wd_d = bus.ad_o; wv_d = 1'b1;
      case (lbc_lanes(bus.high_byte_enable_n, lat_q[0])) // R18 R19
        2'h3: mem_d = bus.ad_o;
        2'h2: mem_d[15:8] = bus.ad_o[15:8];
        2'h1: mem_d[7:0] = bus.ad_o[7:0];
        default: mem_d = mem_q;
      endcase
    end
    // once released, test stays low for the full count
    if (test_release && tn_q) begin // R8
      tn_d = 1'b0; tcnt_d = 3'(TEST_LOW_CYC);
    end else if (!tn_q) begin
      if (tcnt_q != 3'h0) tcnt_d = tcnt_q - 3'h1;
      else tn_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q <= '0; lat_q <= '0; wd_q <= '0; wv_q <= 1'b0; rdy_q <= 1'b1; oe_q <= 1'b0;
      tn_q <= 1'b1; tcnt_q <= '0; ps_q <= CSC_PASSIVE; code_q <= CSC_PASSIVE;
    end else if (clk_en) begin
      mem_q <= mem_d; lat_q <= lat_d; wd_q <= wd_d; wv_q <= wv_d; rdy_q <= rdy_d; oe_q <= oe_d;
      tn_q <= tn_d; tcnt_q <= tcnt_d; ps_q <= ps_d; code_q <= code_d;
    end
  end

  assign bus.per_ad_o = ack_act ? {8'h00, int_type} : mem_q; // R21
  assign bus.per_ad_oe = oe_q & (rd_act | ack_act); // R15
  assign bus.ready = rdy_q;
  assign bus.test_n = tn_q;
  assign bus.hold_req = hold_want;
  assign bus.bus_mode_strap = ~mode_max_n;
  assign last_addr = lat_q;
  assign last_wdata = wd_q;
  assign wdata_valid = wv_q;
endmodule

// ---- verif/lbc_check_assertions.sv ----
`timescale 1ns/1ps
module lbc_check (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        ale,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        interrupt_acknowledge_strobe_n,
  input wire logic        mio,
  input wire logic [15:0] ad_oe,
  input wire logic        ctrl_oe,
  input wire logic        hold_ack,
  input wire logic        lock_n,
  input wire logic        ready,
  input wire logic        bus_mode_strap
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_ALE_ONE_CYCLE: assert property (ale |=> !ale)
    else $error("address strobe longer than one cycle");
  AST_READ_AFTER_ADDR: assert property ($fell(rd_n) |-> $past(ale) && $past(ad_oe) == 16'hffff)
    else $error("read strobe not preceded by address phase");
  AST_READ_FLOATS: assert property (!rd_n |-> ad_oe == 16'h0)
    else $error("bus driven while read strobe active");
  AST_ACK_FLOATS: assert property (!interrupt_acknowledge_strobe_n |-> ad_oe == 16'h0)
    else $error("bus driven during acknowledge");
  AST_SELECT_HELD: assert property (ale |=> $stable(mio) [*2])
    else $error("memory select changed inside cycle");
  AST_STROBE_IN_WAIT: assert property ((!rd_n || !wr_n) && !ready |=> !rd_n || !wr_n)
    else $error("strobe dropped while not ready");
  AST_HOLD_FLOATS: assert property (hold_ack |-> ad_oe == 16'h0 && !ctrl_oe)
    else $error("drivers active during hold");
  AST_LOCK_DEFERS: assert property (!lock_n |-> !hold_ack)
    else $error("hold granted while locked");
  AST_MAX_NO_STROBES: assert property (!bus_mode_strap |-> rd_n && wr_n && interrupt_acknowledge_strobe_n)
    else $error("direct strobe in coded status mode");
endmodule

// ---- verif/test_cpu_local_bus_cycle_unit.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_cpu_local_bus_cycle_unit;
  import lbc_pkg::*;
  logic             core_clk;
  logic             rst_n;
  logic [CMD_W-1:0] cmd_data;
  logic             cmd_valid;
  logic             cmd_ready;
  logic             intr_req;
  logic [9:0]       vec_ptr;
  logic             vec_valid;
  logic             rsp_valid;
  logic             halted;
  logic             waiting;
  logic             mode_max_n;
  logic             test_release;
  logic             hold_want;
  logic [7:0]       int_type;
  logic             slow;
  logic             hold_slow;
  logic [15:0]      last_wdata;
  logic [15:0]      rsp_data;
  logic [15:0]      mem_exp;
  logic [41:0]      q[$];
  logic [41:0]      cur;
  logic [2:0]       prev_csc;
  logic             prev_wr;
  logic             mon_on;
  int               failures;
  int               checks_done;
  int               reads_exp;
  int               reads_seen;

  lbc_if lb ();
  lbc_cpu_end i_lbc_cpu_end (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .bus(lb),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .intr_req(intr_req),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .vec_ptr(vec_ptr), .vec_valid(vec_valid),
    .halted(halted), .waiting(waiting));
  lbc_bus_end i_lbc_bus_end (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .bus(lb),
    .mode_max_n(mode_max_n), .test_release(test_release), .hold_want(hold_want),
    .int_type(int_type), .slow(slow), .last_addr(), .last_wdata(last_wdata), .wdata_valid());
  lbc_check i_lbc_check (.core_clk(core_clk), .rst_n(rst_n), .ale(lb.ale), .rd_n(lb.rd_n),
    .wr_n(lb.wr_n), .interrupt_acknowledge_strobe_n(lb.interrupt_acknowledge_strobe_n),
    .mio(lb.mio), .ad_oe(lb.ad_oe), .ctrl_oe(lb.ctrl_oe), .hold_ack(lb.hold_ack),
    .lock_n(lb.lock_n), .ready(lb.ready), .bus_mode_strap(lb.bus_mode_strap));

  function automatic logic [2:0] csc(input logic [41:0] e);
    case (e[40:38])
      LBC_CMD_READ:  csc = e[37] ? CSC_IO_RD : CSC_MEM_RD;
      LBC_CMD_WRITE: csc = e[37] ? CSC_IO_WR : CSC_MEM_WR;
      LBC_CMD_FETCH: csc = CSC_FETCH;
      LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE:  csc = CSC_INTERRUPT_ACKNOWLEDGE_STROBE;
      default:       csc = CSC_HALT;
    endcase
  endfunction

  // reference model: one queued entry per expected bus cycle {lock, kind, io, hbe_n, addr, data}
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cur = '0;
      mem_exp = '0;
    end else if (mon_on) begin
      if (lb.bus_mode_strap ? lb.ale : (lb.cycle_status_code != CSC_PASSIVE && prev_csc == CSC_PASSIVE)) begin
        `CHK(q.size() > 0, 1'b1)
        if (q.size() > 0) begin
          cur = q.pop_front();
          if (cur[40:38] == LBC_CMD_WRITE) begin
            if (!cur[36]) mem_exp[15:8] = cur[15:8];
            if (!cur[16]) mem_exp[7:0] = cur[7:0];
          end
          if (!lb.bus_mode_strap) begin
            `CHK(lb.cycle_status_code, csc(cur))
          end else if (cur[40:38] != LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE && cur[40:38] != LBC_CMD_HALT) begin
            `CHK({lb.a_hi, lb.ad_o}, cur[35:16])
            `CHK(lb.high_byte_enable_n, cur[36])
            `CHK(lb.mio, ~cur[37])
          end
          `CHK(lb.lock_n, ~cur[41])
        end
      end
      if (cur[40:38] == LBC_CMD_HALT)
        `CHK(lb.rd_n & lb.wr_n & lb.interrupt_acknowledge_strobe_n, 1'b1)
      // only lanes that the cycle selects carry meaningful write data
      if (lb.wr_n === 1'b1 && prev_wr === 1'b0)
        `CHK(last_wdata & {{8{~cur[36]}}, {8{~cur[16]}}}, cur[15:0] & {{8{~cur[36]}}, {8{~cur[16]}}})
      if (vec_valid)
        `CHK(vec_ptr, {int_type, 2'b00})
      if (rsp_valid) begin
        reads_seen++;
        `CHK(rsp_data, mem_exp)
      end
    end
    prev_csc = lb.cycle_status_code;
    prev_wr = lb.wr_n;
  end

  always @(posedge core_clk)
    slow <= hold_slow | ($urandom_range(0, 3) == 0);

  task automatic push(input logic [2:0] k, input logic io = 1'b0, input logic hb = 1'b0,
                      input logic [19:0] a = 20'h0, input logic [15:0] w = 16'h0, input logic lk = 1'b0);
    int n;
    cmd_data <= {k, io, hb, a, w};
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++) @(posedge core_clk);
    cmd_valid <= 1'b0;
    if (k <= LBC_CMD_HALT) q.push_back({lk, k, io, hb, a, w});
    if (k <= LBC_CMD_FETCH) reads_exp++;
    @(posedge core_clk);
  endtask

  task automatic drain();
    int n;
    for (n = 0; n < 5000 && q.size() != 0; n++) @(posedge core_clk);
    repeat (10) @(posedge core_clk);
    `CHK(q.size(), 0)
    `CHK(reads_seen, reads_exp)
  endtask

  task automatic test_done();
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    failures++;
    test_done();
  end

  initial begin
    logic [19:0] a;
    logic [15:0] w;
    int n;
    rst_n = 1'b0; cmd_data = '0; cmd_valid = 1'b0; intr_req = 1'b0; mode_max_n = 1'b1;
    test_release = 1'b0; hold_want = 1'b0; int_type = 8'h00; hold_slow = 1'b0; mon_on = 1'b1;
    failures = 0; checks_done = 0; reads_exp = 0; reads_seen = 0;
    void'($urandom(32'hba73fca3));
    for (int m = 1; m >= 0; m--) begin
      rst_n <= 1'b0;
      mode_max_n <= m[0];
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      mon_on <= 1'b1;
      q.delete();
      @(posedge core_clk);
      // every lane code, memory and i/o space
      for (int i = 0; i < 8; i++) begin
        a = 20'($urandom);
        w = 16'($urandom);
        a[0] = i[0];
        if (i[2]) a[19:16] = 4'h0;
        push(LBC_CMD_WRITE, i[2], i[1], a, w);
        push((i[1] & ~i[2]) ? LBC_CMD_FETCH : LBC_CMD_READ, i[2], i[1], a);
      end
      int_type <= 8'($urandom);
      push(LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE);
      push(LBC_CMD_INTERRUPT_ACKNOWLEDGE_STROBE);
      drain();
      push(LBC_CMD_LOCK);
      push(LBC_CMD_READ, 1'b0, 1'b0, a & 20'hffffe, 16'h0, 1'b1);
      push(LBC_CMD_WRITE, 1'b0, 1'b0, a & 20'hffffe, w, 1'b1);
      hold_want <= 1'b1;
      push(LBC_CMD_UNLOCK);
      for (n = 0; n < 500 && lb.hold_ack !== 1'b1; n++) @(posedge core_clk);
      `CHK(lb.hold_ack, 1'b1)
      `CHK(q.size(), 0)
      hold_want <= 1'b0;
      drain();
      push(LBC_CMD_WAIT);
      repeat (20) @(posedge core_clk);
      `CHK(waiting, 1'b1)
      hold_want <= 1'b1;
      for (n = 0; n < 500 && lb.hold_ack !== 1'b1; n++) @(posedge core_clk);
      `CHK(lb.ad_oe, 16'h0)
      hold_want <= 1'b0;
      repeat (4) @(posedge core_clk);
      `CHK(waiting, 1'b1)
      // an interrupt in the wait costs one refetch of the wait opcode, then waiting resumes
      q.push_back({1'b0, LBC_CMD_FETCH, 2'b00, 20'h0, 16'h0});
      reads_exp++;
      intr_req <= 1'b1;
      for (n = 0; n < 100 && waiting !== 1'b0; n++) @(posedge core_clk);
      intr_req <= 1'b0;
      for (n = 0; n < 100 && waiting !== 1'b1; n++) @(posedge core_clk);
      `CHK(q.size(), 0)
      `CHK(waiting, 1'b1)
      test_release <= 1'b1;
      @(posedge core_clk);
      test_release <= 1'b0;
      for (n = 0; n < 100 && waiting !== 1'b0; n++) @(posedge core_clk);
      `CHK(waiting, 1'b0)
      // stall the responder so the command buffer fills up and refuses
      hold_slow <= 1'b1;
      cmd_valid <= 1'b1;
      for (n = 0; n < 40; n++) begin
        a = 20'($urandom) & 20'hffffe;
        cmd_data <= {LBC_CMD_READ, 2'b00, a, 16'h0};
        @(posedge core_clk);
        if (cmd_ready !== 1'b1) break;
        q.push_back({6'h0, a, 16'h0});
        reads_exp++;
      end
      cmd_valid <= 1'b0;
      `CHK(n inside {[32:34]}, 1'b1)
      hold_slow <= 1'b0;
      drain();
      push(LBC_CMD_HALT);
      for (n = 0; n < 100 && halted !== 1'b1; n++) @(posedge core_clk);
      `CHK(halted, 1'b1)
      hold_want <= 1'b1;
      for (n = 0; n < 500 && lb.hold_ack !== 1'b1; n++) @(posedge core_clk);
      hold_want <= 1'b0;
      repeat (8) @(posedge core_clk);
      `CHK(halted, 1'b1)
      `CHK(q.size(), 0)
      mon_on <= 1'b0;
      intr_req <= 1'b1;
      for (n = 0; n < 100 && halted !== 1'b0; n++) @(posedge core_clk);
      `CHK(halted, 1'b0)
      intr_req <= 1'b0;
    end
    test_done();
  end
endmodule
